// file: common/afs_regs.svh
/*
  register offsets, field positions, reset values and thresholds
  of the amplifier fault supervisor; assumes nothing of its users
*/
`ifndef AFS_REGS_SVH
`define AFS_REGS_SVH
// byte offsets on the register bus
`define AFS_CTRL_OFS 8'h00
`define AFS_AXCFG_OFS 8'h04
`define AFS_CMD_OFS 8'h08
`define AFS_STAT_OFS 8'h0C
`define AFS_QRY0_OFS 8'h10
`define AFS_QRY1_OFS 8'h14
`define AFS_QRY2_OFS 8'h18
`define AFS_QRY3_OFS 8'h1C
`define AFS_HALL_OFS 8'h20
// control fields
`define AFS_CTRL_RUN 0
`define AFS_CTRL_ROUT 1
`define AFS_CTRL_RELAY 2
`define AFS_CTRL_RST 3'h0
// axis config: disable-on-fault low nibble, brush axes high nibble
`define AFS_AXCFG_RST 8'h00
// command fields
`define AFS_CMD_SVON 0
`define AFS_CMD_MOFF 1
// thresholds in volts, amps and degrees
`define AFS_UV_V 8'd18
`define AFS_OV_ON_V 8'd94
`define AFS_OV_OFF_V 8'd90
`define AFS_OC_A 8'd20
`define AFS_OT_C 8'd80
// value the estop query returns while active
`define AFS_ESTOP_CODE 8'h03
`endif

// file: common/afs_pkg.sv
/*
  types of the amplifier fault supervisor; assumes afs_regs.svh
*/
package afs_pkg;
  // estop recovery walk, one-bit steps except armed to run
  typedef enum logic [1:0] {
    AFS_RUN = 2'b00,
    AFS_HOLD = 2'b01,
    AFS_ARMED = 2'b11
  } afs_estop_t;
endpackage : afs_pkg

// file: logic/afs_supervisor.sv
/*
  fault supervisor for a four axis servo amplifier: fault detection,
  enables, fault query and branch request, on an ahb-lite slave.
  assumes analog readings arrive as binary words on hclk, and that
  hall and estop pins are asynchronous
*/
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "afs_regs.svh"

module afs_supervisor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [11:0] hall_pins, // axis n at bits 3n+2..3n
  input wire logic emergency_stop_input, // high while estop pressed
  input wire logic [7:0] supply_volts, // supply in whole volts
  input wire logic [7:0] pair_amps_ab, // summed current, axes 0,1
  input wire logic [7:0] pair_amps_cd, // summed current, axes 2,3
  input wire logic [7:0] sink_temp_c, // averaged heat sink temp
  input wire logic [3:0] over_cont, // axis above continuous limit
  output logic [3:0] amp_enable, // per-axis amplifier enable
  output logic relay_close, // relay joins power to motor leads
  output logic fault_routine // one-cycle branch request
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [12:0] pin_s1_q; // first stage, read only by second
  logic [12:0] pin_s2_q;
  logic [12:0] pin_s3_q;
  logic [12:0] pin_q; // accepted pin levels
  wire [12:0] pin_raw = {emergency_stop_input, hall_pins};
  wire [12:0] pin_agree = ~(pin_s2_q ^ pin_s3_q);

  // three stages; a bit is taken once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_s1_q <= 13'h0000;
      pin_s2_q <= 13'h0000;
      pin_s3_q <= 13'h0000;
      pin_q <= 13'h0000;
    end
    else
    begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_q <= (pin_s3_q & pin_agree) | (pin_q & ~pin_agree);
    end
  end

  wire [11:0] hall_lvl = pin_q[11:0]; // raw levels for the hall query
  wire estop_lvl = pin_q[12];

  // ****************************************
  // software registers
  // ****************************************
  logic [2:0] ctrl_q; // run, routine present, relay fitted
  logic [7:0] axcfg_q; // brush axes, disable-on-fault
  logic wr_q; // write data phase pending
  logic [7:0] waddr_q; // write address held for data phase
  logic [31:0] rdata_q;

  wire [3:0] oe_axis = axcfg_q[3:0];
  wire [3:0] brush_axis_select = axcfg_q[7:4];
  wire prog_run = ctrl_q[`AFS_CTRL_RUN];
  wire rout_there = ctrl_q[`AFS_CTRL_ROUT];
  wire relay_option = ctrl_q[`AFS_CTRL_RELAY];

  // address phase taken on hready with a nonseq or seq transfer
  wire take = hsel & hready & htrans[1];
  wire wr_now = wr_q;
  wire wr_ctrl = wr_now && (waddr_q == `AFS_CTRL_OFS);
  wire wr_axcfg = wr_now && (waddr_q == `AFS_AXCFG_OFS);
  wire wr_cmd = wr_now && (waddr_q == `AFS_CMD_OFS);
  wire servo_enable_cmd = wr_cmd & hwdata[`AFS_CMD_SVON];
  wire drive_disable_cmd = wr_cmd & hwdata[`AFS_CMD_MOFF];

  // ****************************************
  // fault detection
  // ****************************************
  logic [3:0] hall_bad; // illegal state per axis
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      hall_bad[i] = (hall_lvl[3*i +: 3] == 3'b000) ||
                    (hall_lvl[3*i +: 3] == 3'b111);
  end
  wire [3:0] hall_err = hall_bad & ~brush_axis_select;
  wire uv_now = supply_volts < `AFS_UV_V;
  wire oc_ab = pair_amps_ab > `AFS_OC_A;
  wire oc_cd = pair_amps_cd > `AFS_OC_A;
  wire ot_now = sink_temp_c > `AFS_OT_C;

  logic ov_q; // over-voltage with hysteresis
  logic [1:0] oc_q; // latched pair over-current
  logic motor_off_q; // controller motor-off state
  afs_pkg::afs_estop_t est_q;
  afs_pkg::afs_estop_t est_d;

  // set above 94 V, clear below 90 V, hold in the band between
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ov_q <= 1'b0;
    else if (supply_volts > `AFS_OV_ON_V)
      ov_q <= 1'b1;
    else if (supply_volts < `AFS_OV_OFF_V)
      ov_q <= 1'b0;
  end

  // over-current latch: new over-current wins over servo enable
  wire [1:0] oc_now = {oc_cd, oc_ab};
  wire [1:0] oc_d = oc_now | (oc_q & {2{~servo_enable_cmd}});
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      oc_q <= 2'b00;
    else
      oc_q <= oc_d;
  end

  // estop walk: hold until released and motor-off, arm, enable
  always_comb
  begin
    est_d = est_q;
    case (est_q)
      afs_pkg::AFS_RUN:
        if (estop_lvl)
          est_d = afs_pkg::AFS_HOLD;
      afs_pkg::AFS_HOLD:
        if (!estop_lvl && drive_disable_cmd)
          est_d = afs_pkg::AFS_ARMED;
      afs_pkg::AFS_ARMED:
        if (estop_lvl)
          est_d = afs_pkg::AFS_HOLD;
        else if (servo_enable_cmd)
          est_d = afs_pkg::AFS_RUN;
      default:
        est_d = afs_pkg::AFS_HOLD;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      est_q <= afs_pkg::AFS_RUN;
    else
      est_q <= est_d;
  end

  // motor-off: estop and off command set it, servo enable clears it outside HOLD;
  // the set has priority
  wire moff_set = drive_disable_cmd | estop_lvl;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      motor_off_q <= 1'b0;
    else if (moff_set)
      motor_off_q <= 1'b1;
    else if (servo_enable_cmd && est_q != afs_pkg::AFS_HOLD)
      motor_off_q <= 1'b0;
  end

  // ****************************************
  // enables, relay and branch request
  // ****************************************
  wire est_block = (est_q != afs_pkg::AFS_RUN) | estop_lvl;
  wire all_off = uv_now | ov_q | (|oc_q) | ot_now | est_block |
                 motor_off_q;
  wire [3:0] en_d = ~({4{all_off}} | (hall_err & oe_axis));
  wire relay_d = ~(relay_option & motor_off_q);

  // faults that branch; over-voltage is left out on purpose
  wire [7:0] br_src = {hall_err, uv_now, |oc_now, ot_now, estop_lvl};
  logic [7:0] br_prev_q; // reset to zero so faults at start count
  wire [7:0] br_rise = br_src & ~br_prev_q;
  wire br_d = (|br_rise) & prog_run & rout_there;

  logic [3:0] en_q;
  logic relay_q;
  logic br_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      en_q <= 4'h0;
      relay_q <= 1'b0;
      br_q <= 1'b0;
      br_prev_q <= 8'h00;
    end
    else
    begin
      en_q <= en_d;
      relay_q <= relay_d;
      br_q <= br_d;
      br_prev_q <= br_src;
    end
  end

  assign amp_enable = en_q;
  assign relay_close = relay_q;
  assign fault_routine = br_q;

  // ****************************************
  // fault query words, live values only
  // ****************************************
  wire [7:0] qry0 = {3'b000, ot_now, oc_now, ov_q, uv_now};
  wire [7:0] qry1 = {4'h0, hall_err};
  wire [7:0] qry2 = {4'h0, over_cont};
  wire [7:0] qry3 = estop_lvl ? `AFS_ESTOP_CODE : 8'h00;
  wire [7:0] stat = {est_q, oc_q[0] | oc_q[1], motor_off_q, en_q};

  // ****************************************
  // bus slave
  // ****************************************
  // read mux; reading has no side effect on any fault
  logic [31:0] rdata_d;
  always_comb
  begin
    if (haddr == `AFS_CTRL_OFS)
      rdata_d = {29'h0, ctrl_q};
    else if (haddr == `AFS_AXCFG_OFS)
      rdata_d = {24'h0, axcfg_q};
    else if (haddr == `AFS_STAT_OFS)
      rdata_d = {24'h0, stat};
    else if (haddr == `AFS_QRY0_OFS)
      rdata_d = {24'h0, qry0};
    else if (haddr == `AFS_QRY1_OFS)
      rdata_d = {24'h0, qry1};
    else if (haddr == `AFS_QRY2_OFS)
      rdata_d = {24'h0, qry2};
    else if (haddr == `AFS_QRY3_OFS)
      rdata_d = {24'h0, qry3};
    else if (haddr == `AFS_HALL_OFS)
      rdata_d = {20'h0, hall_lvl};
    else
      rdata_d = 32'h0000_0000; // unmapped and command read zero
  end

  // zero wait states: read data latched at the address phase edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      waddr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      wr_q <= take & hwrite;
      if (take)
        waddr_q <= haddr;
      if (take && !hwrite)
        rdata_q <= rdata_d;
    end
  end

  // configuration written in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q <= `AFS_CTRL_RST;
      axcfg_q <= `AFS_AXCFG_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= hwdata[2:0];
      if (wr_axcfg)
        axcfg_q <= hwdata[7:0];
    end
  end

  // fixed answers, held in flops so outputs come from registers
  logic rdy_q;
  logic resp_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rdy_q <= 1'b1;
      resp_q <= 1'b0;
    end
    else
    begin
      rdy_q <= 1'b1;
      resp_q <= 1'b0;
    end
  end
  assign hrdata = rdata_q;
  assign hreadyout = rdy_q;
  assign hresp = resp_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_estop_hit;
    estop_lvl && est_q == afs_pkg::AFS_RUN;
  endsequence
  sequence s_drive_dead;
    (amp_enable == 4'h0) [*2];
  endsequence

  a_ov_disable_on: assert property (
    supply_volts > `AFS_OV_ON_V |-> ##2 amp_enable == 4'h0)
    else $error("over-voltage left drive on");
  a_ov_hold_band: assert property (
    ov_q && supply_volts >= `AFS_OV_OFF_V |=> ov_q)
    else $error("over-voltage released inside band");
  a_uv_disable: assert property (
    uv_now |=> amp_enable == 4'h0)
    else $error("under-voltage left drive on");
  a_oc_latch_hold: assert property (
    oc_q[0] && !servo_enable_cmd |=> oc_q[0])
    else $error("over-current latch dropped");
  a_estop_kill: assert property (
    s_estop_hit |=> s_drive_dead ##0 qry3 == 8'h03)
    else $error("estop did not kill drive");
  a_hall_disable: assert property (
    hall_err[0] && oe_axis[0] |=> !amp_enable[0])
    else $error("hall error left axis on");
  a_branch_rise: assert property (
    br_rise != 8'h00 && prog_run && rout_there |=> fault_routine)
    else $error("fault routine not requested");
  a_ov_no_branch: assert property (
    fault_routine |-> $past(br_src) != 8'h00)
    else $error("branch without branching fault");
  a_relay_open: assert property (
    motor_off_q && relay_option |=> !relay_close)
    else $error("relay closed in motor off");
  a_query_pure: assert property (
    take && !hwrite && !oc_now[0] && !servo_enable_cmd |=>
      $stable(oc_q[0]))
    else $error("query read altered fault state");

endmodule : afs_supervisor
`default_nettype wire

// file: testbench/afs_power_stage.sv
/*
  power stage and hall sensor model facing the supervisor; assumes
  the bench sets the demanded readings and this model shows them on hclk
*/
`timescale 1ns/1ns
`default_nettype none

module afs_power_stage (
  input wire logic hclk,
  input wire logic [3:0] amp_enable,
  input wire logic [11:0] hall_set,
  input wire logic [7:0] volts_set,
  input wire logic [15:0] amps_set,
  input wire logic [7:0] temp_set,
  output logic [11:0] hall_pins,
  output logic [7:0] supply_volts,
  output logic [7:0] pair_amps_ab,
  output logic [7:0] pair_amps_cd,
  output logic [7:0] sink_temp_c
);
  // a disabled pair carries no current, so a trip removes its own cause
  wire logic ab_on = |amp_enable[1:0];
  wire logic cd_on = |amp_enable[3:2];

  // readings follow the demand one edge later, like a sampled converter
  always_ff @(posedge hclk)
  begin
    hall_pins <= hall_set;
    supply_volts <= volts_set;
    pair_amps_ab <= ab_on ? amps_set[7:0] : 8'h00;
    pair_amps_cd <= cd_on ? amps_set[15:8] : 8'h00;
    sink_temp_c <= temp_set;
  end
endmodule : afs_power_stage
`default_nettype wire

// file: testbench/testbench.sv
/*
  self-checking bench of the fault supervisor; assumes the zero-wait
  ahb-lite slave of the design and the power stage model beside it
*/
`timescale 1ns/1ns
`default_nettype none
`include "afs_regs.svh"
// compare two values, count the compare and report a miss
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
  error_cnt++; $display("CHECK FAILED t=%0t got %h want %h", $time, \
  got, exp); end end

module testbench;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
  logic [7:0] haddr = 8'h00, volts_set = 8'd48, temp_set = 8'd40;
  logic [1:0] htrans = 2'b00;
  logic [31:0] hwdata = 32'h0, rd, hrdata;
  logic [11:0] hall_set = 12'h249; // 001 on every axis: legal
  logic [15:0] amps_set = 16'h0505;
  logic [3:0] over_cont = 4'h0, amp_enable;
  logic estop = 1'b0, hreadyout, hresp, relay_close, fault_routine;
  logic [11:0] hall_pins;
  logic [7:0] supply_volts, pair_amps_ab, pair_amps_cd, sink_temp_c;
  int error_cnt = 0, checked = 0, pulses = 0;

  always #25 hclk = ~hclk;
  // branch pulses counted off the active edge to avoid races
  always @(negedge hclk) if (fault_routine === 1'b1) pulses++;

  afs_supervisor u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .hall_pins(hall_pins),
    .emergency_stop_input(estop), .supply_volts(supply_volts),
    .pair_amps_ab(pair_amps_ab), .pair_amps_cd(pair_amps_cd),
    .sink_temp_c(sink_temp_c), .over_cont(over_cont),
    .amp_enable(amp_enable), .relay_close(relay_close),
    .fault_routine(fault_routine));

  afs_power_stage u_amp (.hclk(hclk), .amp_enable(amp_enable),
    .hall_set(hall_set), .volts_set(volts_set), .amps_set(amps_set),
    .temp_set(temp_set), .hall_pins(hall_pins),
    .supply_volts(supply_volts), .pair_amps_ab(pair_amps_ab),
    .pair_amps_cd(pair_amps_cd), .sink_temp_c(sink_temp_c));

  // ******** run control ********
  task automatic close_out;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // let pins pass the synchroniser and faults reach the enables
  task automatic settle;
    repeat (8) @(posedge hclk);
  endtask : settle

  // ******** bus master ********
  // bounded wait for hready; a stuck slave ends the run
  task automatic wait_ready;
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 40);
    if (hreadyout !== 1'b1)
    begin
      error_cnt++;
      close_out();
    end
  endtask : wait_ready

  task automatic xfer(input logic [7:0] a, input logic w,
      input logic [31:0] wd);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    `CHK(rd, exp)
    `CHK(hresp, 1'b0)
  endtask : rdc

  // ******** scenarios ********
  task automatic t_regs;
    rdc(`AFS_CTRL_OFS, 32'h0);
    wr(8'h40, 32'hFFFF_FFFF); // unmapped: ignored
    rdc(8'h40, 32'h0);
    rdc(`AFS_CMD_OFS, 32'h0);
    wr(`AFS_CTRL_OFS, 32'h3); // program running, routine present
    wr(`AFS_AXCFG_OFS, 32'h0F);
    rdc(`AFS_AXCFG_OFS, 32'h0F);
    `CHK(amp_enable, 4'hF)
  endtask : t_regs

  // each axis in turn with both illegal codes, then masked cases
  task automatic t_hall;
    int p;
    for (int i = 0; i < 8; i++)
    begin
      p = pulses;
      hall_set[3*(i%4) +: 3] <= (i < 4) ? 3'b000 : 3'b111;
      settle();
      rdc(`AFS_QRY1_OFS, 32'h1 << (i % 4));
      rdc(`AFS_HALL_OFS, {20'h0, hall_set});
      `CHK(amp_enable[i%4], 1'b0)
      `CHK(pulses, p + 1)
      hall_set <= 12'h249;
      settle();
      `CHK(amp_enable, 4'hF)
    end
    wr(`AFS_AXCFG_OFS, 32'h0E); // no disable-on-fault on axis 0
    hall_set[2:0] <= 3'b111;
    settle();
    `CHK(amp_enable, 4'hF)
    wr(`AFS_AXCFG_OFS, 32'h1F); // axis 0 brush type
    rdc(`AFS_QRY1_OFS, 32'h0);
    hall_set <= 12'h249;
    // legal levels must pass the synchroniser before the mask drops,
    // or a stray branch lands in the next scenario's pulse count
    settle();
    wr(`AFS_AXCFG_OFS, 32'h0F);
  endtask : t_hall

  // supply walk through both thresholds and the hysteresis band
  task automatic t_supply;
    logic [7:0] v [6] = '{`AFS_UV_V - 8'd1, `AFS_UV_V,
      `AFS_OV_ON_V + 8'd1, `AFS_OV_ON_V, `AFS_OV_OFF_V,
      `AFS_OV_OFF_V - 8'd1};
    logic [3:0] en [6] = '{4'h0, 4'hF, 4'h0, 4'h0, 4'h0, 4'hF};
    logic [31:0] q [3] = '{32'h1, 32'h0, 32'h2};
    int p;
    for (int i = 0; i < 6; i++)
    begin
      p = pulses;
      volts_set <= v[i];
      settle();
      `CHK(amp_enable, en[i])
      `CHK(pulses, p + (i == 0 ? 1 : 0))
      if (i < 3)
        rdc(`AFS_QRY0_OFS, q[i]);
    end
    volts_set <= 8'd48;
  endtask : t_supply

  // per pair: limit current holds, one amp more trips and latches
  task automatic t_oc;
    int p;
    wr(`AFS_AXCFG_OFS, 32'h0); // no disable-on-fault anywhere
    for (int k = 0; k < 2; k++)
    begin
      amps_set <= 16'(`AFS_OC_A) << (8 * k);
      settle();
      `CHK(amp_enable, 4'hF)
      p = pulses;
      amps_set <= 16'(`AFS_OC_A + 8'd1) << (8 * k);
      settle();
      `CHK(amp_enable, 4'h0)
      `CHK(pulses, p + 1)
      rdc(`AFS_STAT_OFS, 32'h20);
      rdc(`AFS_QRY0_OFS, 32'h0);
      amps_set <= 16'h0505;
      settle();
      `CHK(amp_enable, 4'h0)
      wr(`AFS_CMD_OFS, 32'h1 << `AFS_CMD_SVON);
      settle();
      `CHK(amp_enable, 4'hF)
    end
    wr(`AFS_AXCFG_OFS, 32'h0F);
  endtask : t_oc

  task automatic t_temp;
    int p;
    p = pulses;
    temp_set <= `AFS_OT_C + 8'd1;
    settle();
    `CHK(amp_enable, 4'h0)
    `CHK(pulses, p + 1)
    rdc(`AFS_QRY0_OFS, 32'h10);
    temp_set <= `AFS_OT_C;
    settle();
    `CHK(amp_enable, 4'hF)
    for (int i = 0; i < 4; i++)
    begin
      over_cont <= 4'h1 << i;
      settle();
      rdc(`AFS_QRY2_OFS, 32'h1 << i);
    end
    over_cont <= 4'h0;
  endtask : t_temp

  // stop, early enable refused, then off, delay, enable
  task automatic t_estop;
    int p;
    p = pulses;
    estop <= 1'b1;
    settle();
    `CHK(amp_enable, 4'h0)
    repeat (3) rdc(`AFS_QRY3_OFS, `AFS_ESTOP_CODE);
    `CHK(pulses, p + 1)
    rdc(`AFS_STAT_OFS, {24'h0, afs_pkg::AFS_HOLD, 6'h10});
    wr(`AFS_CMD_OFS, 32'h1 << `AFS_CMD_SVON);
    estop <= 1'b0;
    settle();
    `CHK(amp_enable, 4'h0)
    rdc(`AFS_QRY3_OFS, 32'h0);
    wr(`AFS_CMD_OFS, 32'h1 << `AFS_CMD_MOFF);
    settle(); // host delay before the enable
    wr(`AFS_CMD_OFS, 32'h1 << `AFS_CMD_SVON);
    settle();
    `CHK(amp_enable, 4'hF)
  endtask : t_estop

  task automatic t_relay;
    wr(`AFS_CTRL_OFS, 32'h7); // relay fitted
    settle();
    `CHK(relay_close, 1'b1)
    wr(`AFS_CMD_OFS, 32'h1 << `AFS_CMD_MOFF);
    settle();
    `CHK(relay_close, 1'b0)
    `CHK(amp_enable, 4'h0)
  endtask : t_relay

  // ******** main sequence ********
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    t_regs();
    t_hall();
    t_supply();
    t_oc();
    t_temp();
    t_estop();
    t_relay();
    close_out();
  end

  // hang guard
  initial
  begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    close_out();
  end
endmodule : testbench
`default_nettype wire
